// [tb_top.sv]
// Purpose: self-checking bench for ulms_status
// Assumes: zero wait state apb slave, bounded waits anyway
// Notes:   without fifo the holding store is one character deep
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
   logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                  pwrite = 1'b0, rx_done = 1'b0, pready, pslverr, last_err;
   logic                  dtr_n, rts_n, out1_n, out2_n, modem_irq, irq;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0, prdata, d;
   logic [3:0]            want = 4'hf;
   ulms_pkg::ulms_char_s  rx_char = '0;
   ulms_pkg::ulms_modem_s modem_in;
   int                    miscompares = 0, checks = 0;
   always #2.5 pclk = ~pclk;
   ulms_status ulms_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_done(rx_done), .rx_char(rx_char), .modem_in(modem_in),
      .dtr_n(dtr_n), .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n),
      .modem_irq(modem_irq), .irq(irq));
   ulms_modem_peer ulms_modem_peer_i (.pclk(pclk), .want(want), .modem_in(modem_in));
   task automatic results();
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // a missing answer ends the run through the closing report
      if (pready !== 1'b1) begin
         miscompares++;
         results();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      apb(1'b1, a, v, x);
   endtask
   task automatic send(input logic pe, input logic [7:0] v);
      @(posedge pclk);
      rx_done <= 1'b1;
      rx_char <= '{perr: pe, data: v};
      @(posedge pclk);
      rx_done <= 1'b0;
   endtask
   task automatic pins(input logic [3:0] v);
      want <= v;
      repeat (8) @(posedge pclk);
   endtask
   task automatic t_modem();
      rd(8'h1c, 32'h0);
      `CHK(last_err, 1'b1)
      rd(ulms_pkg::ADDR_MODEM, 32'h0);
      wr(ulms_pkg::ADDR_IMASK, 32'h4);
      pins(4'h0);
      `CHK(irq, 1'b1)
      `CHK(modem_irq, 1'b1)
      rd(ulms_pkg::ADDR_MODEM, 32'hfb);
      rd(ulms_pkg::ADDR_MODEM, 32'hf0);
      `CHK(modem_irq, 1'b0)
      wr(ulms_pkg::ADDR_ISTAT, 32'h4);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      pins(4'h4);
      rd(ulms_pkg::ADDR_MODEM, 32'hb4);
      pins(4'hf);
      rd(ulms_pkg::ADDR_MODEM, 32'h0b);
   endtask
   task automatic t_loop();
      logic [5:0] mc [2] = '{6'h1a, 6'h15};
      logic [3:0] ex [2] = '{4'h9, 4'h6};
      for (int i = 0; i < 2; i++) begin
         wr(ulms_pkg::ADDR_MCTRL, {26'h0, mc[i]});
         repeat (8) @(posedge pclk);
         apb(1'b0, ulms_pkg::ADDR_MODEM, 32'h0, d);
         `CHK(d[7:4], ex[i])
         `CHK({dtr_n, rts_n, out1_n, out2_n}, 4'hf)
      end
      wr(ulms_pkg::ADDR_MCTRL, 32'h03);
      repeat (8) @(posedge pclk);
      `CHK({dtr_n, rts_n, out1_n, out2_n}, 4'h3)
      apb(1'b0, ulms_pkg::ADDR_MODEM, 32'h0, d);
      `CHK(d[7:4], 4'h0)
      wr(ulms_pkg::ADDR_MCTRL, 32'h0);
   endtask
   task automatic t_rx();
      wr(ulms_pkg::ADDR_ISTAT, 32'hf);
      send(1'b0, 8'h5a);
      rd(ulms_pkg::ADDR_LINE, 32'h1);
      send(1'b0, 8'ha5);
      rd(ulms_pkg::ADDR_LINE, 32'h3);
      rd(ulms_pkg::ADDR_RXDATA, 32'h5a);
      rd(ulms_pkg::ADDR_LINE, 32'h0);
      send(1'b1, 8'h33);
      repeat (3) @(posedge pclk);
      rd(ulms_pkg::ADDR_LINE, 32'h5);
      rd(ulms_pkg::ADDR_RXDATA, 32'h33);
      rd(ulms_pkg::ADDR_LINE, 32'h0);
      `CHK(irq, 1'b0)
      rd(ulms_pkg::ADDR_ISTAT, 32'hb);
      wr(ulms_pkg::ADDR_IMASK, 32'hf);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      wr(ulms_pkg::ADDR_ISTAT, 32'hf);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
   endtask
   task automatic t_fifo();
      wr(ulms_pkg::ADDR_MCTRL, 32'h20);
      for (int i = 0; i < 16; i++) send(i == 1, 8'(i));
      rd(ulms_pkg::ADDR_LINE, 32'h1);
      send(1'b0, 8'hff);
      rd(ulms_pkg::ADDR_LINE, 32'h3);
      rd(ulms_pkg::ADDR_RXDATA, 32'h0);
      repeat (3) @(posedge pclk);
      rd(ulms_pkg::ADDR_LINE, 32'h5);
      for (int i = 1; i < 16; i++) rd(ulms_pkg::ADDR_RXDATA, {24'h0, 8'(i)});
      rd(ulms_pkg::ADDR_LINE, 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_modem();
      t_loop();
      t_rx();
      t_fifo();
      results();
   end
   initial begin
      #100000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire

// [ulms_modem_peer.sv]
// Purpose: modem side model driving the four status pins
// Assumes: levels are requested by the bench, active low pins
// Notes:   idle level is inactive high, as with pulled-up lines
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_peer (
   // clock
   input  wire logic                  pclk,
   // requested levels cd, ri, dsr, cts
   input  wire logic [3:0]            want,
   // pins toward the block
   output var  ulms_pkg::ulms_modem_s modem_in
);
   initial modem_in = 4'hf;
   // registered so pins move right after an edge, never mid-cycle
   always @(posedge pclk) modem_in <= want;
endmodule
`default_nettype wire

// [ulms_pkg.sv]
// Purpose: constants and types for the uart line and modem status block
// Assumes: APB slave, 32-bit data, one clock pclk at 200 MHz
// Notes:   register map and field positions live here only
// Contract
// - line status bit 2 shows a parity error, else reads 0
// - with the FIFO on, parity flag follows the head character
// - line status bit 1 sets when a character completes into a full FIFO
// - on overrun the new character overwrites the shift register copy
// - on overrun nothing is pushed, stored characters stay intact
// - line status bit 0 set while any received character is held
// - line status bit 0 clear when holding register and FIFO are empty
// - modem status bits 3..0 flag CD, RI, DSR, CTS changes
// - reading modem status clears only the change bits that the read returned
// - bit 7 is inverted CD, in loopback modem control bit 3
// - bit 6 is inverted RI, in loopback modem control bit 2
// - bit 5 is inverted DSR, in loopback modem control bit 0
// - bit 4 is inverted CTS, in loopback modem control bit 1
// - RI change bit sets only on RI input rising from 0 to 1
// - modem interrupt request while any modem status bit 3..0 is set
package ulms_pkg;
   localparam logic [7:0] ADDR_LINE   = 8'h00;
   localparam logic [7:0] ADDR_MODEM  = 8'h04;
   localparam logic [7:0] ADDR_MCTRL  = 8'h08;
   localparam logic [7:0] ADDR_ISTAT  = 8'h0c;
   localparam logic [7:0] ADDR_IMASK  = 8'h10;
   localparam logic [7:0] ADDR_RXDATA = 8'h14;
   // line status fields
   localparam int LS_READY  = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   // modem control fields
   localparam int MC_DTR   = 0;
   localparam int MC_RTS   = 1;
   localparam int MC_OUT1  = 2;
   localparam int MC_OUT2  = 3;
   localparam int MC_LOOP  = 4;
   localparam int MC_FIFO  = 5;
   localparam int MC_WIDTH = 6;
   // interrupt status fields
   localparam int IS_PARITY  = 0;
   localparam int IS_OVERRUN = 1;
   localparam int IS_MODEM   = 2;
   localparam int IS_READY   = 3;
   localparam int IS_WIDTH   = 4;
   // receive buffer
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W      = 4;
   localparam int CNT_W      = 5;
   localparam logic [CNT_W-1:0] CNT_FULL_FIFO = 5'h10;
   localparam logic [CNT_W-1:0] CNT_FULL_HOLD = 5'h01;
   localparam logic [1:0] PRIME_DONE = 2'h2;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ANS  = 2'b10
   } ulms_apb_e;
   // modem inputs, active low at the pins: cd, ri, dsr, cts
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } ulms_modem_s;
   typedef struct packed {
      logic       perr;
      logic [7:0] data;
   } ulms_char_s;
endpackage

// [ulms_status.sv]
// Purpose: line status, modem status and interrupt logic of one uart channel
// Assumes: receiver hands over finished characters with their parity result
// Notes:   read side effects act only on bits the read actually returned
`timescale 1ns/1ps
`default_nettype none
module ulms_status (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   // receiver
   input  wire logic                  rx_done,
   input  wire ulms_pkg::ulms_char_s  rx_char,
   // modem pins
   input  wire ulms_pkg::ulms_modem_s modem_in,
   output var  logic                  dtr_n,
   output var  logic                  rts_n,
   output var  logic                  out1_n,
   output var  logic                  out2_n,
   // interrupts
   output var  logic                  modem_irq,
   output var  logic                  irq
);
   typedef struct packed {
      ulms_pkg::ulms_apb_e                apb;
      logic [31:0]                        rdata;
      logic                               ready;
      logic                               err;
      logic [7:0]                         raddr;
      ulms_pkg::ulms_modem_s              sync1;
      ulms_pkg::ulms_modem_s              sync2;
      ulms_pkg::ulms_modem_s              prev;
      logic [1:0]                         prime;
      logic [3:0]                         delta;
      logic [ulms_pkg::MC_WIDTH-1:0]      mctrl;
      logic [ulms_pkg::IS_WIDTH-1:0]      istat;
      logic [ulms_pkg::IS_WIDTH-1:0]      imask;
      logic                               perr;
      logic                               ovr;
      logic                               head_new;
      ulms_pkg::ulms_char_s               shift;
      logic [ulms_pkg::PTR_W-1:0]         wptr;
      logic [ulms_pkg::PTR_W-1:0]         rptr;
      logic [ulms_pkg::CNT_W-1:0]         count;
      logic                               ready_prev;
      logic                               pin_dtr_n;
      logic                               pin_rts_n;
      logic                               pin_out1_n;
      logic                               pin_out2_n;
      logic                               irq_modem;
      logic                               irq_any;
   } ulms_state_s;

   ulms_state_s         s_q;
   ulms_state_s         s_d;
   ulms_pkg::ulms_char_s mem_q [ulms_pkg::FIFO_DEPTH];
   logic                push;

   function automatic logic [31:0] widen8(input logic [7:0] v);
      widen8 = {24'h00_0000, v};
   endfunction

   // effective modem levels, pin polarity; loopback feeds control bits back
   ulms_pkg::ulms_modem_s eff;
   always_comb begin
      if (s_q.mctrl[ulms_pkg::MC_LOOP]) begin
         eff.cd_n  = ~s_q.mctrl[ulms_pkg::MC_OUT2];
         eff.ri_n  = ~s_q.mctrl[ulms_pkg::MC_OUT1];
         eff.dsr_n = ~s_q.mctrl[ulms_pkg::MC_DTR];
         eff.cts_n = ~s_q.mctrl[ulms_pkg::MC_RTS];
      end else begin
         eff = s_q.sync2;
      end
   end

   logic [7:0] line_val;
   logic [7:0] modem_val;
   logic       fifo_on;
   logic       full;
   logic       has_data;
   always_comb begin
      fifo_on  = s_q.mctrl[ulms_pkg::MC_FIFO];
      full     = fifo_on ? (s_q.count == ulms_pkg::CNT_FULL_FIFO)
                         : (s_q.count == ulms_pkg::CNT_FULL_HOLD);
      has_data = (s_q.count != '0);
      line_val = 8'h00;
      line_val[ulms_pkg::LS_READY]   = has_data;
      line_val[ulms_pkg::LS_OVERRUN] = s_q.ovr;
      line_val[ulms_pkg::LS_PARITY]  = s_q.perr;
      // complement of the pin level is the asserted state
      modem_val = {~eff.cd_n, ~eff.ri_n, ~eff.dsr_n, ~eff.cts_n, s_q.delta};
   end

   // a completed character enters storage only when there is room
   assign push = rx_done && !full;

   always_comb begin
      logic       setup;
      logic       acc;
      logic [3:0] chg;
      logic       pop;
      logic [3:0] ev;
      setup = 1'b0;
      acc   = 1'b0;
      chg   = 4'h0;
      pop   = 1'b0;
      ev    = 4'h0;
      s_d   = s_q;

      // apb: answer lands one cycle after setup, zero wait states
      setup = psel && !penable && (s_q.apb == ulms_pkg::APB_IDLE);
      acc   = psel && penable && (s_q.apb == ulms_pkg::APB_ANS);
      if (setup) begin
         s_d.apb   = ulms_pkg::APB_ANS;
         s_d.ready = 1'b1;
         s_d.raddr = paddr;
         s_d.err   = 1'b0;
         s_d.rdata = 32'h0000_0000;
         case (paddr)
            ulms_pkg::ADDR_LINE:   s_d.rdata = widen8(line_val);
            ulms_pkg::ADDR_MODEM:  s_d.rdata = widen8(modem_val);
            ulms_pkg::ADDR_MCTRL:  s_d.rdata = widen8({2'b00, s_q.mctrl});
            ulms_pkg::ADDR_ISTAT:  s_d.rdata = widen8({4'h0, s_q.istat});
            ulms_pkg::ADDR_IMASK:  s_d.rdata = widen8({4'h0, s_q.imask});
            ulms_pkg::ADDR_RXDATA: s_d.rdata = widen8(mem_q[s_q.rptr].data);
            default:               s_d.err   = 1'b1;
         endcase
         if (pwrite) begin
            s_d.rdata = 32'h0000_0000;
         end
      end else if (acc) begin
         s_d.apb   = ulms_pkg::APB_IDLE;
         s_d.ready = 1'b0;
         s_d.err   = 1'b0;
      end

      // synchronise pins before anything looks at them
      s_d.sync1 = modem_in;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = eff;
      if (s_q.prime != ulms_pkg::PRIME_DONE) begin
         s_d.prime = s_q.prime + 2'h1;
      end

      // reads clear only what they returned, so a fresh change is not lost
      if (acc && !pwrite && !s_q.err) begin
         if (s_q.raddr == ulms_pkg::ADDR_MODEM) begin
            s_d.delta = s_q.delta & ~s_q.rdata[3:0];
         end
         if (s_q.raddr == ulms_pkg::ADDR_LINE) begin
            if (s_q.rdata[ulms_pkg::LS_PARITY]) s_d.perr = 1'b0;
            if (s_q.rdata[ulms_pkg::LS_OVERRUN]) s_d.ovr = 1'b0;
         end
         if (s_q.raddr == ulms_pkg::ADDR_RXDATA && has_data) begin
            pop = 1'b1;
         end
      end

      // change detection; skipped until the synchroniser holds real levels
      if (s_q.prime == ulms_pkg::PRIME_DONE) begin
         chg[3] = eff.cd_n != s_q.prev.cd_n;
         chg[2] = eff.ri_n && !s_q.prev.ri_n;
         chg[1] = eff.dsr_n != s_q.prev.dsr_n;
         chg[0] = eff.cts_n != s_q.prev.cts_n;
      end
      s_d.delta = s_d.delta | chg;

      // receive path
      if (rx_done) begin
         s_d.shift = rx_char;
         if (full) begin
            s_d.ovr = 1'b1;
            ev[ulms_pkg::IS_OVERRUN] = 1'b1;
         end
      end
      if (push) begin
         s_d.wptr = s_q.wptr + 4'h1;
      end
      if (pop) begin
         s_d.rptr = s_q.rptr + 4'h1;
         s_d.head_new = 1'b1;
      end
      if (push && !pop && s_q.count == '0) begin
         s_d.head_new = 1'b1;
      end
      case ({push, pop})
         2'b10:   s_d.count = s_q.count + 5'h01;
         2'b01:   s_d.count = s_q.count - 5'h01;
         default: s_d.count = s_q.count;
      endcase

      // parity flag tracks whichever character reaches the head
      if (s_q.head_new && has_data && !pop) begin
         s_d.head_new = 1'b0;
         if (mem_q[s_q.rptr].perr) begin
            s_d.perr = 1'b1;
            ev[ulms_pkg::IS_PARITY] = 1'b1;
         end
      end

      // interrupt status, write one to clear, events win over the clear
      s_d.ready_prev = has_data;
      ev[ulms_pkg::IS_READY] = has_data && !s_q.ready_prev;
      ev[ulms_pkg::IS_MODEM] = |chg;
      if (acc && pwrite) begin
         case (s_q.raddr)
            ulms_pkg::ADDR_MCTRL: s_d.mctrl = pwdata[ulms_pkg::MC_WIDTH-1:0];
            ulms_pkg::ADDR_ISTAT: s_d.istat = s_q.istat & ~pwdata[ulms_pkg::IS_WIDTH-1:0];
            ulms_pkg::ADDR_IMASK: s_d.imask = pwdata[ulms_pkg::IS_WIDTH-1:0];
            default:              s_d.mctrl = s_q.mctrl;
         endcase
      end
      s_d.istat = s_d.istat | ev;
      // fifo mode switch empties storage, as old data has the wrong depth
      if (s_d.mctrl[ulms_pkg::MC_FIFO] != s_q.mctrl[ulms_pkg::MC_FIFO]) begin
         s_d.wptr  = '0;
         s_d.rptr  = '0;
         s_d.count = '0;
      end

      // pins go inactive in loopback so the modem sees nothing
      s_d.pin_dtr_n  = ~s_d.mctrl[ulms_pkg::MC_DTR]  | s_d.mctrl[ulms_pkg::MC_LOOP];
      s_d.pin_rts_n  = ~s_d.mctrl[ulms_pkg::MC_RTS]  | s_d.mctrl[ulms_pkg::MC_LOOP];
      s_d.pin_out1_n = ~s_d.mctrl[ulms_pkg::MC_OUT1] | s_d.mctrl[ulms_pkg::MC_LOOP];
      s_d.pin_out2_n = ~s_d.mctrl[ulms_pkg::MC_OUT2] | s_d.mctrl[ulms_pkg::MC_LOOP];
      s_d.irq_modem  = |s_d.delta;
      s_d.irq_any    = |(s_d.istat & s_d.imask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.apb        <= ulms_pkg::APB_IDLE;
         s_q.sync1      <= '1;
         s_q.sync2      <= '1;
         s_q.prev       <= '1;
         s_q.pin_dtr_n  <= 1'b1;
         s_q.pin_rts_n  <= 1'b1;
         s_q.pin_out1_n <= 1'b1;
         s_q.pin_out2_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // storage has no reset; count guards pops and the parity check, but an RXDATA read returns mem_q[rptr] even when empty
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_q[s_q.wptr] <= rx_char;
      end
   end

   assign prdata    = s_q.rdata;
   assign pready    = s_q.ready;
   assign pslverr   = s_q.err;
   assign dtr_n     = s_q.pin_dtr_n;
   assign rts_n     = s_q.pin_rts_n;
   assign out1_n    = s_q.pin_out1_n;
   assign out2_n    = s_q.pin_out2_n;
   assign modem_irq = s_q.irq_modem;
   assign irq       = s_q.irq_any;
endmodule
`default_nettype wire

// [ulms_status_checker.sv]
// Purpose: port checker for ulms_status
// Assumes: bench keeps modem pins quiet around modem status reads
// Notes:   bound to every ulms_status instance
`timescale 1ns/1ps
`default_nettype none
module ulms_status_checker (
   // clock, reset and apb
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           prdata,
   input  wire logic                  pready,
   input  wire logic                  pslverr,
   // receiver, modem and interrupts
   input  wire logic                  rx_done,
   input  wire ulms_pkg::ulms_modem_s modem_in,
   input  wire logic                  modem_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_mod;
   logic rd_line;
   assign rd_mod  = pready && !pwrite && paddr == ulms_pkg::ADDR_MODEM;
   assign rd_line = pready && !pwrite && paddr == ulms_pkg::ADDR_LINE;
   AST_PREADY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_SETUP_ANS: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer not clean");
   AST_HIGH_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_MODEM_CHG:
      assert property ($changed({modem_in.cd_n, modem_in.dsr_n, modem_in.cts_n})
         |-> ##[2:6] modem_irq) else $error("modem change not flagged");
   AST_RI_RISE: assert property ($rose(modem_in.ri_n) |-> ##[2:6] modem_irq)
      else $error("ri rise not flagged");
   AST_READ_CLR: assert property (rd_mod |-> ##2 !modem_irq)
      else $error("modem read left request");
   AST_IRQ_CAUSE: assert property (rd_mod && prdata[3:0] != 4'h0 |-> modem_irq)
      else $error("change bit without request");
   AST_READY_BIT: assert property (rd_line && $past(rx_done, 3) |-> prdata[0])
      else $error("ready bit missing");
   cover property (rd_mod && prdata[2]);
   cover property (rd_line && prdata[1]);
   cover property (pslverr);
endmodule
bind ulms_status ulms_status_checker ulms_status_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_done(rx_done), .modem_in(modem_in),
   .modem_irq(modem_irq));
`default_nettype wire
